// file: verification/asr_host_tb.sv
// self-checking bench for the async sram host controller
`timescale 1ns/1ps
module asr_host_tb
    import asr_pkg::*;
;
    localparam int PU = 20;
    logic ref_clk = 1'b0;
    logic reset = 1'b1;
    logic req_valid = 1'b0;
    asr_req_t req = '0;
    logic req_ready, rsp_valid, m_oe;
    logic [7:0] rsp_data, m_dq, data_pins_in;
    asr_pins_t pins;
    int n_errors = 0;
    int checks_done = 0;

    always #4 ref_clk = ~ref_clk;
    // released lines toggle
    assign data_pins_in = pins.data_oe ? pins.data_out :
        m_oe ? m_dq : {4{ref_clk, ~ref_clk}};

    asr_host #(.POWERUP_CYC(PU)) u_asr_host (.ref_clk(ref_clk), .reset(reset),
        .req_valid(req_valid), .req(req), .req_ready(req_ready), .rsp_valid(rsp_valid),
        .rsp_data(rsp_data), .pins(pins), .data_pins_in(data_pins_in));
    asr_mem_model u_asr_mem_model (.pins(pins), .dq_in(data_pins_in), .dq_out(m_dq),
        .dq_oe(m_oe));

    ////////////////////////////////////////////////////////////////////////////////
    task automatic results();
        if (n_errors == 0 && checks_done > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : results

    task automatic chk8(input logic [7:0] g, input logic [7:0] e);
        checks_done++;
        if (g !== e) begin
            n_errors++;
            $display("mismatch %0t data %h exp %h", $time, g, e);
        end
    endtask : chk8

    task automatic chkb(input logic g, input logic e);
        checks_done++;
        if (g !== e) begin
            n_errors++;
            $display("mismatch %0t flag %b exp %b", $time, g, e);
        end
    endtask : chkb

    task automatic wait_rdy();
        for (int i = 0; i < PU + 20; i++) begin
            @(negedge ref_clk);
            if (req_ready === 1'b1) return;
        end
        n_errors++;
        results();
    endtask : wait_rdy

    task automatic op(input logic w, input logic [20:0] a, input logic [7:0] d,
        output int n);
        @(posedge ref_clk);
        req_valid <= 1'b1;
        req <= '{write: w, addr: a, wdata: d};
        wait_rdy();
        @(posedge ref_clk);
        req_valid <= 1'b0;
        for (n = 1; n < 20; n++) begin
            @(negedge ref_clk);
            if (rsp_valid === 1'b1) return;
        end
        n_errors++;
        results();
    endtask : op

    ////////////////////////////////////////////////////////////////////////////////
    task automatic t_powerup();
        for (int i = 0; i < PU - 2; i++) begin
            @(negedge ref_clk);
            chkb(req_ready, 1'b0);
            chkb(pins.chip_select_low_n, 1'b1);
        end
        wait_rdy();
    endtask : t_powerup

    task automatic t_rw();
        logic [20:0] a [3] = '{21'h000000, 21'h1FFFFF, 21'h0AAAAA};
        logic [7:0] d [3] = '{8'h5A, 8'hA5, 8'hFF};
        int n;
        for (int i = 0; i < 3; i++) begin
            op(1'b1, a[i], d[i], n);
            chkb(n == 6, 1'b1);
        end
        for (int i = 0; i < 3; i++) begin
            op(1'b0, a[i], 8'h00, n);
            chkb(n == 7, 1'b1);
            chk8(rsp_data, d[i]);
            @(negedge ref_clk);
            chkb(rsp_valid, 1'b0);
        end
    endtask : t_rw

    task automatic t_reset_mid();
        int n;
        op(1'b1, 21'h000123, 8'h3C, n);
        @(posedge ref_clk);
        req_valid <= 1'b1;
        req <= '{write: 1'b1, addr: 21'h000456, wdata: 8'hC3};
        wait_rdy();
        repeat (3) @(posedge ref_clk);
        req_valid <= 1'b0;
        reset <= 1'b1;
        @(posedge ref_clk);
        reset <= 1'b0;
        @(negedge ref_clk);
        chkb(pins.chip_select_high, 1'b0);
        chkb(pins.data_oe, 1'b0);
        chkb(req_ready, 1'b0);
        wait_rdy();
        op(1'b0, 21'h000123, 8'h00, n);
        chk8(rsp_data, 8'h3C);
    endtask : t_reset_mid

    // no drive fight on the data pins
    always @(negedge ref_clk) begin
        if (pins.data_oe === 1'b1) chkb(m_oe, 1'b0);
    end

    initial begin
        repeat (3) @(posedge ref_clk);
        reset <= 1'b0;
        t_powerup();
        t_rw();
        t_reset_mid();
        results();
    end
endmodule : asr_host_tb

// file: verification/asr_mem_model.sv
// behavioural 2M x 8 asynchronous static memory
`timescale 1ns/1ps
module asr_mem_model
    import asr_pkg::*;
(
    input wire asr_pins_t pins,
    input wire logic [ASR_DATA_W-1:0] dq_in,
    output logic [ASR_DATA_W-1:0] dq_out,
    output logic dq_oe
);
    logic [ASR_DATA_W-1:0] mem [0:(1 << ASR_ADDR_W)-1];
    logic sel;
    logic wr;
    assign sel = !pins.chip_select_low_n && pins.chip_select_high;
    assign wr = sel && !pins.write_strobe_n;
    assign dq_oe = sel && !pins.output_enable_n && pins.write_strobe_n;
    assign dq_out = mem[pins.addr];
    always @(negedge wr) begin
        mem[pins.addr] = dq_in;
    end
endmodule : asr_mem_model

// file: verilog/asr_host.sv
// host controller driving an asynchronous 2M x 8 static memory
`timescale 1ns/1ps
module asr_host
    import asr_pkg::*;
#(
    parameter int POWERUP_CYC = ASR_POWERUP_CYC
)
(
    input wire logic ref_clk,
    input wire logic reset,
    input wire logic req_valid,
    input wire asr_req_t req,
    output logic req_ready,
    output logic rsp_valid,
    output logic [ASR_DATA_W-1:0] rsp_data,
    output asr_pins_t pins,
    input wire logic [ASR_DATA_W-1:0] data_pins_in
);
    ////////////////////////////////////////////////////////////////////////
    typedef enum logic [5:0] {
        S_POWERUP = 6'h01,
        S_IDLE = 6'h02,
        S_SETUP = 6'h04,
        S_ACTIVE = 6'h08,
        S_END = 6'h10,
        S_SAMPLE = 6'h20
    } asr_state_t;

    typedef struct packed {
        asr_state_t fsm;
        logic [31:0] wait_cnt;
        logic [1:0] phase;
        logic is_write;
        asr_pins_t pins;
        logic rsp_valid;
        logic [ASR_DATA_W-1:0] rsp_data;
    } asr_host_state_t;

    asr_host_state_t st;
    asr_host_state_t next_st;
    logic [ASR_DATA_W-1:0] data_sync;

    function automatic logic [1:0] phase_max();
        return 2'(ASR_PHASE_CYC);
    endfunction : phase_max

    asr_sync u_sync (
        .ref_clk(ref_clk),
        .reset(reset),
        .din(data_pins_in),
        .dout(data_sync)
    );

    ////////////////////////////////////////////////////////////////////////
    always_comb begin
        next_st = st;
        next_st.rsp_valid = 1'b0;
        case (st.fsm)
            S_POWERUP: begin
                if (st.wait_cnt >= 32'(POWERUP_CYC - 1)) begin
                    next_st.fsm = S_IDLE;
                end else begin
                    next_st.wait_cnt = st.wait_cnt + 32'h1;
                end
            end
            S_IDLE: begin
                if (req_valid) begin
                    next_st.pins.addr = req.addr;
                    next_st.pins.data_out = req.wdata;
                    next_st.is_write = req.write;
                    next_st.phase = ASR_PHASE_RESET;
                    next_st.fsm = S_SETUP;
                end
            end
            S_SETUP: begin
                next_st.pins.chip_select_low_n = 1'b0;
                next_st.pins.chip_select_high = 1'b1;
                if (st.is_write) begin
                    next_st.pins.write_strobe_n = 1'b0;
                    next_st.pins.data_oe = 1'b1;
                    next_st.pins.output_enable_n = 1'b1;
                end else begin
                    next_st.pins.write_strobe_n = 1'b1;
                    next_st.pins.output_enable_n = 1'b0;
                end
                next_st.fsm = S_ACTIVE;
            end
            S_ACTIVE: begin
                if (st.phase >= phase_max()) begin
                    next_st.fsm = st.is_write ? S_END : S_SAMPLE;
                    next_st.pins.write_strobe_n = 1'b1;
                end else begin
                    next_st.phase = st.phase + 2'h1;
                end
            end
            S_SAMPLE: begin
                next_st.phase = st.phase - 2'h1;
                if (st.phase == 2'h1) begin
                    next_st.rsp_data = data_sync;
                    next_st.rsp_valid = 1'b1;
                    next_st.pins.chip_select_low_n = 1'b1;
                    next_st.pins.chip_select_high = 1'b0;
                    next_st.pins.output_enable_n = 1'b1;
                    next_st.fsm = S_IDLE;
                end
            end
            S_END: begin
                next_st.pins.data_oe = 1'b0;
                next_st.pins.chip_select_low_n = 1'b1;
                next_st.pins.chip_select_high = 1'b0;
                next_st.rsp_valid = 1'b1;
                next_st.fsm = S_IDLE;
            end
            default: begin
                next_st.fsm = S_IDLE;
            end
        endcase
    end

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            st.fsm <= S_POWERUP;
            st.wait_cnt <= ASR_WAIT_RESET;
            st.phase <= ASR_PHASE_RESET;
            st.is_write <= 1'b0;
            st.pins.addr <= '0;
            st.pins.chip_select_low_n <= 1'b1;
            st.pins.chip_select_high <= 1'b0;
            st.pins.output_enable_n <= 1'b1;
            st.pins.write_strobe_n <= 1'b1;
            st.pins.data_out <= '0;
            st.pins.data_oe <= 1'b0;
            st.rsp_valid <= 1'b0;
            st.rsp_data <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign req_ready = (st.fsm == S_IDLE);
    assign pins = st.pins;
    assign rsp_valid = st.rsp_valid;
    assign rsp_data = st.rsp_data;

    ////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (reset);

    sequence sel_on;
        !pins.chip_select_low_n && pins.chip_select_high;
    endsequence

    // strobe rises while both selects still hold, so the strobe ends the write
    sequence write_end;
        sel_on and $rose(pins.write_strobe_n);
    endsequence

    sequence data_released;
        pins.data_oe && $stable(pins.data_out) ##1 !pins.data_oe;
    endsequence

    AST_NO_ACCESS_AT_POWERUP: assert property (
        st.fsm == S_POWERUP |-> pins.chip_select_low_n && !pins.chip_select_high)
        else $error("access during power-up wait");
    AST_READ_STROBE_HIGH: assert property (
        sel_on and !pins.output_enable_n |-> pins.write_strobe_n && !pins.data_oe)
        else $error("write strobe low during read");
    AST_WRITE_DRIVES_DATA: assert property (
        !pins.write_strobe_n |-> sel_on and pins.data_oe)
        else $error("write without select or data");
    AST_ADDR_STABLE: assert property (
        sel_on |-> $stable(pins.addr))
        else $error("address moved while selected");
    AST_WRITE_LENGTH: assert property (
        $fell(pins.write_strobe_n) |-> !pins.write_strobe_n [*3] ##1 pins.write_strobe_n)
        else $error("write pulse wrong length");
    AST_DATA_HOLD: assert property (
        write_end |-> data_released)
        else $error("data not held past write end");
    AST_STROBE_ENDS_WRITE: assert property (
        $rose(pins.write_strobe_n) && !$past(reset) |-> sel_on)
        else $error("write not ended by the strobe");
    AST_WRITE_OE_HIGH: assert property (
        !pins.write_strobe_n |-> pins.output_enable_n)
        else $error("output enable low during write");
    AST_ADDR_BEFORE_SELECT: assert property (
        $rose(pins.chip_select_high) |-> $stable(pins.addr))
        else $error("address changed at select assertion");
    AST_READ_SELECT_HELD: assert property (
        $fell(pins.output_enable_n) |-> sel_on [*5] ##1 !pins.chip_select_high)
        else $error("select dropped during read");
    AST_POWERUP_DONE: assert property (
        req_ready |-> st.wait_cnt == 32'(POWERUP_CYC - 1))
        else $error("ready before power-up wait ended");
    AST_SELECT_COMBINED: assert property (
        pins.chip_select_low_n == !pins.chip_select_high)
        else $error("selects disagree");
    AST_READ_RESPONSE: assert property (
        $fell(pins.output_enable_n) |-> ##[4:6] rsp_valid)
        else $error("read response not timely");
endmodule : asr_host

// file: verilog/asr_pkg.sv
// shared constants and types for the async sram host controller
package asr_pkg;
    localparam int ASR_ADDR_W = 21;
    localparam int ASR_DATA_W = 8;
    localparam int ASR_CLK_PERIOD_PS = 8000;
    localparam int ASR_POWERUP_MS = 1;
    localparam int ASR_POWERUP_CYC = (ASR_POWERUP_MS * 1000000000 + ASR_CLK_PERIOD_PS - 1)
        / ASR_CLK_PERIOD_PS;
    localparam int ASR_SETUP_PS = 12000;
    localparam int ASR_PHASE_CYC = (ASR_SETUP_PS + ASR_CLK_PERIOD_PS - 1) / ASR_CLK_PERIOD_PS;
    localparam logic [1:0] ASR_PHASE_RESET = 2'h0;
    localparam logic [31:0] ASR_WAIT_RESET = 32'h0;

    typedef struct packed {
        logic [ASR_ADDR_W-1:0] addr;
        logic chip_select_low_n;
        logic chip_select_high;
        logic output_enable_n;
        logic write_strobe_n;
        logic [ASR_DATA_W-1:0] data_out;
        logic data_oe;
    } asr_pins_t;

    typedef struct packed {
        logic write;
        logic [ASR_ADDR_W-1:0] addr;
        logic [ASR_DATA_W-1:0] wdata;
    } asr_req_t;
endpackage : asr_pkg

// file: verilog/asr_sync.sv
// two-flop synchroniser for the data pins
`timescale 1ns/1ps
module asr_sync
    import asr_pkg::*;
(
    input wire logic ref_clk,
    input wire logic reset,
    input wire logic [ASR_DATA_W-1:0] din,
    output logic [ASR_DATA_W-1:0] dout
);
    typedef struct packed {
        logic [ASR_DATA_W-1:0] s1;
        logic [ASR_DATA_W-1:0] s2;
    } asr_sync_state_t;
    asr_sync_state_t st;
    asr_sync_state_t next_st;

    always_comb begin
        next_st.s1 = din;
        next_st.s2 = st.s1;
    end

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign dout = st.s2;
endmodule : asr_sync
